// ---- verilog/ckpc_cfg.svh ----
`ifndef CKPC_CFG_SVH
`define CKPC_CFG_SVH

// timing
`define CKPC_CLK_PERIOD_NS 10
`define CKPC_STEP_MIN_NS 100
// strictly longer than 100 ns: 11 samples at 10 ns
`define CKPC_STEP_MIN_CYC ((`CKPC_STEP_MIN_NS / `CKPC_CLK_PERIOD_NS) + 1)
`define CKPC_LOCK_PPM 1000
`define CKPC_PPM_SCALE 1000000
`define CKPC_CAL_CYC 5000
`define CKPC_LOS_CYC 64

// register offsets
`define CKPC_REG_CTRL 4'h0
`define CKPC_REG_STAT 4'h1
`define CKPC_REG_IRQ_STAT 4'h2
`define CKPC_REG_IRQ_MASK 4'h3
`define CKPC_REG_PHASE 4'h4
`define CKPC_REG_FREQ 4'h5

// ctrl field positions
`define CKPC_CTRL_SPREAD_OUTS 3:0
`define CKPC_CTRL_FSTEP_OUTS 7:4
`define CKPC_CTRL_SE_FB 8
`define CKPC_CTRL_ZDM 9
`define CKPC_CTRL_RST 32'h0000_0000

// irq bit positions
`define CKPC_IRQ_PUP 0
`define CKPC_IRQ_PDN 1
`define CKPC_IRQ_FUP 2
`define CKPC_IRQ_FDN 3
`define CKPC_IRQ_LOS 4
`define CKPC_IRQ_LOL 5

`endif

// ---- verilog/ckpc_pkg.sv ----
package ckpc_pkg;

  typedef enum logic [1:0] {
    CKPC_ROLE_CLOCK_SE,
    CKPC_ROLE_PHASE,
    CKPC_ROLE_FREQ
  } ckpc_role_e;

  typedef struct packed {
    logic up;
    logic down;
  } ckpc_step_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ckpc_bus_s;

endpackage

// ---- verilog/ckpc_step_qual.sv ----
`timescale 1ns/1ps
`include "ckpc_cfg.svh"

module ckpc_step_qual #(
  parameter int MIN_CYC = `CKPC_STEP_MIN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw pin
  input wire logic pin,
  // one pulse per request
  output logic step
);

  typedef enum {CKPC_SQ_IDLE, CKPC_SQ_HIGH, CKPC_SQ_ARMED, CKPC_SQ_LOW} ckpc_sq_e;

  logic meta_q;
  logic sync_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic step_q;
  logic step_d;
  ckpc_sq_e st_q;
  ckpc_sq_e st_d;
  wire logic cnt_done = (cnt_q >= 16'(MIN_CYC - 1));

  // two-stage synchroniser; only sync_q feeds logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // high of qualifying width, then qualifying low, then one pulse
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    step_d = 1'b0;
    unique case (st_q)
      CKPC_SQ_IDLE: begin
        cnt_d = 16'h0000;
        if (sync_q) begin
          // this first high sample already counts toward the width
          st_d = CKPC_SQ_HIGH;
          cnt_d = 16'h0001;
        end
      end
      CKPC_SQ_HIGH: begin
        if (!sync_q) begin
          st_d = CKPC_SQ_IDLE;
        end else if (cnt_done) begin
          st_d = CKPC_SQ_ARMED;
          cnt_d = 16'h0000;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      CKPC_SQ_ARMED: begin
        cnt_d = 16'h0000;
        if (!sync_q) begin
          st_d = CKPC_SQ_LOW;
          cnt_d = 16'h0001;
        end
      end
      CKPC_SQ_LOW: begin
        if (sync_q) begin
          // low too short: discard, count this high as the start of a new request
          st_d = CKPC_SQ_HIGH;
          cnt_d = 16'h0001;
        end else if (cnt_done) begin
          st_d = CKPC_SQ_IDLE;
          step_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= CKPC_SQ_IDLE;
      cnt_q <= 16'h0000;
      step_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
    end
  end

  assign step = step_q;

endmodule

// ---- verilog/ckpc_pin_ctrl.sv ----
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "ckpc_cfg.svh"

module ckpc_pin_ctrl #(
  parameter ckpc_pkg::ckpc_role_e ROLE = ckpc_pkg::CKPC_ROLE_PHASE,
  parameter int CAL_CYC = `CKPC_CAL_CYC,
  parameter int LOS_CYC = `CKPC_LOS_CYC,
  parameter int WIN_BITS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // multipurpose pins
  input wire logic control_input_first,
  input wire logic control_input_second,
  input wire logic spread_control_input,
  // feedback sources
  input wire logic diff_feedback_in,
  input wire logic single_ended_feedback_in,
  // detector activity from the synthesis core
  input wire logic ref_edge,
  input wire logic fb_edge,
  // reference clock from control_input_first in clock role, and the selected feedback
  output logic single_ended_ref_in,
  output logic feedback_sel,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // step and spread controls toward the synthesis core
  output ckpc_pkg::ckpc_step_s phase_step,
  output ckpc_pkg::ckpc_step_s freq_step,
  output logic [3:0] spread_on,
  output logic signal_loss,
  output logic lock_loss,
  // open-drain alarm
  output logic loss_alarm_o,
  output logic loss_alarm_oe,
  output logic irq
);

  // ****************************************
  // pin qualification
  // ****************************************
  logic up_raw;
  logic dn_raw;
  logic sp_meta_q;
  logic sp_sync_q;
  wire logic spread_enable_n = sp_sync_q;
  wire logic step_role = (ROLE != ckpc_pkg::CKPC_ROLE_CLOCK_SE);

  ckpc_step_qual u_up (.clk(clk), .nrst(nrst), .pin(control_input_first), .step(up_raw));
  ckpc_step_qual u_dn (.clk(clk), .nrst(nrst), .pin(control_input_second), .step(dn_raw));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_meta_q <= 1'b1;
      sp_sync_q <= 1'b1;
    end else begin
      sp_meta_q <= spread_control_input;
      sp_sync_q <= sp_meta_q;
    end
  end

  // clock role passes control_input_first straight through; no step logic acts
  assign single_ended_ref_in = (ROLE == ckpc_pkg::CKPC_ROLE_CLOCK_SE) & control_input_first;

  // ****************************************
  // control register
  // ****************************************
  logic [31:0] ctrl_q;
  logic [5:0] ist_q;
  logic [5:0] imask_q;
  logic [15:0] phase_q;
  logic [15:0] freq_q;

  wire logic [3:0] spread_outs = ctrl_q[`CKPC_CTRL_SPREAD_OUTS];
  wire logic [3:0] fstep_outs = ctrl_q[`CKPC_CTRL_FSTEP_OUTS];
  wire logic zdm = ctrl_q[`CKPC_CTRL_ZDM];

  assign spread_on = spread_enable_n ? 4'h0 : spread_outs;
  // stepped output blocked while spread runs on it
  wire logic fstep_blocked = |(spread_on & fstep_outs);

  wire logic do_pup = step_role & (ROLE == ckpc_pkg::CKPC_ROLE_PHASE) & up_raw;
  wire logic do_pdn = step_role & (ROLE == ckpc_pkg::CKPC_ROLE_PHASE) & dn_raw;
  wire logic do_fup = (ROLE == ckpc_pkg::CKPC_ROLE_FREQ) & up_raw & ~fstep_blocked;
  wire logic do_fdn = (ROLE == ckpc_pkg::CKPC_ROLE_FREQ) & dn_raw & ~fstep_blocked;

  // the core applies steps; counters here only track net steps taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_step <= '0;
      freq_step <= '0;
      phase_q <= 16'h0000;
      freq_q <= 16'h0000;
    end else begin
      phase_step <= '{up: do_pup, down: do_pdn};
      freq_step <= '{up: do_fup, down: do_fdn};
      phase_q <= phase_q + {15'h0000, do_pup} - {15'h0000, do_pdn};
      freq_q <= freq_q + {15'h0000, do_fup} - {15'h0000, do_fdn};
    end
  end

  // feedback only meaningful in zero-delay mode
  assign feedback_sel = zdm & (ctrl_q[`CKPC_CTRL_SE_FB] & (ROLE == ckpc_pkg::CKPC_ROLE_CLOCK_SE)
    ? single_ended_feedback_in : diff_feedback_in);

  // ****************************************
  // calibration, signal and lock monitors
  // ****************************************
  logic [15:0] cal_q;
  logic [7:0] los_q;
  logic [WIN_BITS-1:0] win_q;
  logic [WIN_BITS-1:0] refc_q;
  logic [WIN_BITS-1:0] fbc_q;
  logic lol_q;
  wire logic cal_busy = (cal_q != 16'(CAL_CYC));
  wire logic win_end = (win_q == {WIN_BITS{1'b1}});
  wire logic [WIN_BITS-1:0] diff_cnt = (refc_q > fbc_q) ? refc_q - fbc_q : fbc_q - refc_q;
  // diff/ref > 1000 ppm, i.e. diff * 1e6 > ref * 1000
  wire logic [63:0] lhs = 64'(diff_cnt) * 64'(`CKPC_PPM_SCALE);
  wire logic [63:0] rhs = 64'(refc_q) * 64'(`CKPC_LOCK_PPM);
  wire logic over_ppm = (lhs > rhs);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cal_q <= 16'h0000;
      los_q <= 8'h00;
      win_q <= '0;
      refc_q <= '0;
      fbc_q <= '0;
      lol_q <= 1'b0;
    end else begin
      if (cal_busy) begin
        cal_q <= cal_q + 16'h0001;
      end
      if (ref_edge) begin
        los_q <= 8'h00;
      end else if (los_q != 8'(LOS_CYC)) begin
        los_q <= los_q + 8'h01;
      end
      win_q <= win_q + 1'b1;
      if (win_end) begin
        lol_q <= over_ppm;
        refc_q <= '0;
        fbc_q <= '0;
      end else begin
        refc_q <= refc_q + {{(WIN_BITS-1){1'b0}}, ref_edge};
        fbc_q <= fbc_q + {{(WIN_BITS-1){1'b0}}, fb_edge};
      end
    end
  end

  assign signal_loss = (los_q == 8'(LOS_CYC));
  assign lock_loss = lol_q & ~cal_busy;

  // open drain: pull low when clear, release so pull-up reads 1 on loss
  assign loss_alarm_o = 1'b0;
  assign loss_alarm_oe = ~(signal_loss | lock_loss);

  // ****************************************
  // interrupts and register port
  // ****************************************
  wire logic [5:0] ev = {lock_loss, signal_loss, do_fdn, do_fup, do_pdn, do_pup};
  wire logic hit_ctrl = (reg_addr == `CKPC_REG_CTRL);
  wire logic hit_ist = (reg_addr == `CKPC_REG_IRQ_STAT);
  wire logic hit_imask = (reg_addr == `CKPC_REG_IRQ_MASK);
  wire logic [5:0] w1c = (reg_wr & hit_ist) ? reg_wdata[5:0] : 6'h00;
  logic [31:0] rd_mux;

  always_comb begin
    unique case (reg_addr)
      `CKPC_REG_CTRL: rd_mux = {22'h000000, ctrl_q[9:0]};
      `CKPC_REG_STAT: rd_mux = {28'h0000000, cal_busy, loss_alarm_oe, lock_loss, signal_loss};
      `CKPC_REG_IRQ_STAT: rd_mux = {26'h0000000, ist_q};
      `CKPC_REG_IRQ_MASK: rd_mux = {26'h0000000, imask_q};
      `CKPC_REG_PHASE: rd_mux = {16'h0000, phase_q};
      `CKPC_REG_FREQ: rd_mux = {16'h0000, freq_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `CKPC_CTRL_RST;
      ist_q <= 6'h00;
      imask_q <= 6'h00;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr & hit_ctrl) begin
        ctrl_q <= {22'h000000, reg_wdata[9:0]};
      end
      if (reg_wr & hit_imask) begin
        imask_q <= reg_wdata[5:0];
      end
      // set wins over a same-cycle clear
      ist_q <= (ist_q & ~w1c) | ev;
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign irq = |(ist_q & imask_q);

endmodule

// ---- tb/ckpc_host_model.sv ----
`timescale 1ns/1ps
module ckpc_host_model (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire logic sel,
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  // pins toward the device, grounded while idle
  output logic control_input_first,
  output logic control_input_second,
  output logic busy
);
  initial {control_input_first, control_input_second, busy} = 3'h0;
  // short counts are only ever asked for by refusal tests
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      control_input_first <= !sel;
      control_input_second <= sel;
      repeat (hi) @(posedge clk);
      {control_input_first, control_input_second} <= 2'h0;
      repeat (lo) @(posedge clk);
      busy <= 1'b0;
    end
  end
endmodule

// ---- tb/ckpc_pin_ctrl_checker.sv ----
`timescale 1ns/1ps
module ckpc_pin_ctrl_checker #(
  parameter ckpc_pkg::ckpc_role_e ROLE = ckpc_pkg::CKPC_ROLE_PHASE
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic control_input_first,
  input wire logic control_input_second,
  input wire logic spread_control_input,
  // outputs
  input wire logic single_ended_ref_in,
  input wire ckpc_pkg::ckpc_step_s phase_step,
  input wire ckpc_pkg::ckpc_step_s freq_step,
  input wire logic [3:0] spread_on,
  input wire logic lock_loss,
  input wire logic signal_loss,
  input wire logic loss_alarm_o,
  input wire logic loss_alarm_oe
);
  // ********
  // cycles since each pin was last high
  // ********
  logic [5:0] up_age_q;
  logic [5:0] dn_age_q;
  ckpc_pkg::ckpc_step_s any_step;
  assign any_step = phase_step | freq_step;
  always_ff @(posedge clk) begin
    up_age_q <= control_input_first ? 6'h0 : up_age_q + 6'(up_age_q != 6'h3f);
    dn_age_q <= control_input_second ? 6'h0 : dn_age_q + 6'(dn_age_q != 6'h3f);
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_alarm_level: assert property (loss_alarm_oe == !(signal_loss || lock_loss))
    else $error("alarm pin disagrees with loss flags");
  a_alarm_drive: assert property (!loss_alarm_o)
    else $error("alarm pin driven high");
  a_spread_off: assert property (spread_control_input [*4] |-> spread_on == 4'h0)
    else $error("spread on while disabled");
  a_role_fixed: assert property ((ROLE == ckpc_pkg::CKPC_ROLE_CLOCK_SE) ?
    (single_ended_ref_in == control_input_first && any_step == 2'h0) :
    (!single_ended_ref_in &&
    (ROLE == ckpc_pkg::CKPC_ROLE_PHASE ? freq_step : phase_step) == 2'h0))
    else $error("step of the wrong role");
  a_step_once: assert property (any_step != 2'h0 |=> (any_step == 2'h0) [*8])
    else $error("step pulse repeated");
  a_up_pin: assert property (any_step.up |-> up_age_q inside {[11:30]})
    else $error("up step without qualified request");
  a_down_pin: assert property (any_step.down |-> dn_age_q inside {[11:30]})
    else $error("down step without qualified request");
  a_cal_mask: assert property ($rose(nrst) |-> (!lock_loss) [*8])
    else $error("lock loss during calibration");
endmodule
bind ckpc_pin_ctrl ckpc_pin_ctrl_checker #(.ROLE(ROLE)) u_ckpc_pin_ctrl_checker (.*);

// ---- tb/ckpc_pin_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "ckpc_cfg.svh"
module ckpc_pin_ctrl_tb_top;
  logic clk, nrst, control_input_first, control_input_second, busy, go, sel, reg_wr, reg_rd;
  logic spread_control_input, diff_feedback_in, single_ended_feedback_in, ref_on, fb_half;
  logic ref_edge = 1'b0;
  logic fb_edge = 1'b0;
  logic fblock = 1'b0;
  logic [3:0] reg_addr;
  logic [3:0] map [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
  logic [7:0] hi, lo;
  logic [31:0] reg_wdata, rd1, rd2, seed;
  wire logic single_ended_ref_in, feedback_sel, signal_loss, lock_loss;
  wire logic loss_alarm_o, loss_alarm_oe, irq, fb_se;
  wire logic [31:0] reg_rdata, rdata2;
  wire logic [3:0] spread_on;
  wire ckpc_pkg::ckpc_step_s phase_step, freq_step;
  // pull-up on the open-drain alarm
  wire logic alarm_pin = loss_alarm_oe ? loss_alarm_o : 1'b1;
  int failures = 0;
  int tests_run = 0;
  int pnet = 0;
  int fnet = 0;
  ckpc_pin_ctrl #(.CAL_CYC(20), .WIN_BITS(6)) u_ckpc_pin_ctrl (.*);
  ckpc_pin_ctrl #(.ROLE(ckpc_pkg::CKPC_ROLE_FREQ), .CAL_CYC(20), .WIN_BITS(6))
    u_ckpc_pin_ctrl_freq (.*, .single_ended_ref_in(), .feedback_sel(), .reg_rdata(rdata2),
    .phase_step(), .freq_step(), .spread_on(), .signal_loss(), .lock_loss(),
    .loss_alarm_o(), .loss_alarm_oe(), .irq());
  ckpc_pin_ctrl #(.ROLE(ckpc_pkg::CKPC_ROLE_CLOCK_SE), .CAL_CYC(20), .WIN_BITS(6))
    u_ckpc_pin_ctrl_se (.*, .single_ended_ref_in(), .feedback_sel(fb_se), .reg_rdata(),
    .phase_step(), .freq_step(), .spread_on(), .signal_loss(), .lock_loss(),
    .loss_alarm_o(), .loss_alarm_oe(), .irq());
  ckpc_host_model u_ckpc_host_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    ref_edge <= ref_on;
    fb_edge <= ref_on & ~(fb_half & fb_edge);
  end
  // ********
  // expectations and bus cycles
  // ********
  function automatic int delta(input logic s, input logic [7:0] h);
    return h < 8'(`CKPC_STEP_MIN_CYC) ? 0 : (s ? -1 : 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 {rd1, rd2} = {reg_rdata, rdata2};
  endtask
  task automatic step(input logic s, input logic [7:0] h);
    @(posedge clk);
    {go, sel, hi, lo} <= {1'b1, s, h, 8'd20 + 8'({$random(seed)} % 9)};
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 300 && busy; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    pnet += delta(s, h);
    if (!fblock) fnet += delta(s, h);
  endtask
  task automatic counts();
    rd(4'h4);
    chk("phase", rd1, {16'h0000, 16'(pnet)});
    chk("phase in freq role", rd2, 32'h0);
    rd(4'h5);
    chk("freq", rd2, {16'h0000, 16'(fnet)});
    chk("freq in phase role", rd1, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    seed = 32'h4eba42c9;
    {nrst, go, sel, hi, lo, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {spread_control_input, ref_on, fb_half, diff_feedback_in, single_ended_feedback_in} = 5'h18;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wr(4'hf, 32'hffff_ffff);
    foreach (map[i]) begin
      rd(map[i]);
      chk("reset value", rd1, 32'h0);
    end
    $display("reset test done");
    // boundary widths first, then random requests
    step(1'b0, 8'd11);
    step(1'b1, 8'd11);
    step(1'b0, 8'd10);
    step(1'b1, 8'd3);
    repeat (6) step(1'($random(seed)), 8'd12 + 8'({$random(seed)} % 9));
    counts();
    $display("step test done");
    rd(4'h2);
    chk("step status", rd1 & 32'h3, 32'h3);
    chk("irq masked", 32'(irq), 32'h0);
    wr(4'h3, 32'h1);
    #1 chk("irq unmasked", 32'(irq), 32'h1);
    wr(4'h2, 32'h3f);
    #1 chk("irq cleared", 32'(irq), 32'h0);
    $display("irq test done");
    wr(4'h0, 32'h11);
    spread_control_input <= 1'b0;
    fblock = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("spread on", 32'(spread_on), 32'h1);
    step(1'b0, 8'd15);
    counts();
    spread_control_input <= 1'b1;
    fblock = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("spread off", 32'(spread_on), 32'h0);
    step(1'b1, 8'd15);
    counts();
    $display("spread test done");
    @(posedge clk);
    {diff_feedback_in, single_ended_feedback_in} <= 2'b10;
    wr(4'h0, 32'h200);
    #1 chk("diff feedback", 32'(feedback_sel), 32'h1);
    chk("diff feedback clock role", 32'(fb_se), 32'h1);
    wr(4'h0, 32'h300);
    // no single-ended feedback pin exists in the stepping role
    #1 chk("single feedback unconfigured", 32'(feedback_sel), 32'h1);
    chk("single feedback", 32'(fb_se), 32'h0);
    wr(4'h0, 32'h100);
    #1 chk("feedback off", {feedback_sel, fb_se}, 32'h0);
    $display("feedback test done");
    ref_on <= 1'b0;
    repeat (80) @(posedge clk);
    #1 chk("signal loss", {signal_loss, alarm_pin}, 32'h3);
    ref_on <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("alarm clear", 32'(alarm_pin), 32'h0);
    fb_half <= 1'b1;
    wr(4'h3, 32'h20);
    repeat (200) @(posedge clk);
    #1 chk("lock loss", {lock_loss, alarm_pin, irq}, 32'h7);
    fb_half <= 1'b0;
    repeat (200) @(posedge clk);
    wr(4'h2, 32'h3f);
    #1 chk("lock regained", {lock_loss, alarm_pin, irq}, 32'h0);
    $display("loss test done");
    give_verdict();
  end
endmodule
